// >>> src/codec_serial_pkg.sv
package codec_serial_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
  localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
  localparam logic [7:0] OFS_SLOT_MASK  = 8'h0C;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  localparam logic [2:0] OFS_BUF_REGION = 3'h1;  // 0x20..0x3F: rx words, then tx words

  // field positions
  localparam int EN_POS    = 0;  // control_reg_one: module_enable_bit
  localparam int FSD_POS   = 1;  // control_reg_one: frame_sync_direction
  localparam int IDLE_POS  = 2;  // control_reg_one: idle_output_mode
  localparam int WS_LSB    = 0;  // control_reg_two: word_size_field
  localparam int FSG_LSB   = 4;  // control_reg_two: slots per frame minus one
  localparam int BCKD_POS  = 8;  // control_reg_two: bit_clock_direction
  localparam int BCG_LSB   = 0;  // control register three: bit clock divider

  localparam int WORD_BITS = 16;
  localparam int BUF_WORDS = 4;
  localparam int BUF_AW    = 3;
  localparam int BCG_BITS  = 12;

  typedef enum {ENG_IDLE, ENG_RUN} engine_state_type;

  typedef struct packed {
    logic                 enable;
    logic                 fs_dir;
    logic                 idle_mode;
    logic                 bck_dir;
    logic [3:0]           ws;
    logic [3:0]           fsg;
    logic [BCG_BITS-1:0]  bcg;
    logic [WORD_BITS-1:0] slot_mask;
  } cfg_type;

  typedef struct packed {
    logic                 bclk;
    logic [BCG_BITS-1:0]  bcg_cnt;
    logic [3:0]           bit_cnt;
    logic [3:0]           slot_cnt;
    logic [1:0]           buf_addr;
    logic                 in_frame;
    logic                 start_pend;
    logic                 fs_out;
    logic                 sdo;
    logic                 sdo_oe;
    logic                 bck_oe;
    logic                 fs_oe;
  } engine_type;

  typedef struct packed {
    logic                 we;
    logic [BUF_AW-1:0]    addr;
    logic [WORD_BITS-1:0] data;
  } mem_wr_type;

  // reset values
  localparam cfg_type    CFG_RST = '0;
  localparam engine_type ENG_RST = '0;

endpackage

// >>> src/buffer_mem.sv
`timescale 1ns/1ps
// shadow buffer: bus port writes tx words, serial port writes rx words
module buffer_mem (
  input  wire logic                                 clock_i,
  input  wire logic                                 rstn_i,
  input  wire logic                                 ce_i,
  input  wire codec_serial_pkg::mem_wr_type         a_wr_i,
  input  wire logic [codec_serial_pkg::BUF_AW-1:0]  a_raddr_i,
  input  wire codec_serial_pkg::mem_wr_type         b_wr_i,
  input  wire logic [codec_serial_pkg::BUF_AW-1:0]  b_raddr_i,
  output logic      [codec_serial_pkg::WORD_BITS-1:0] a_rdata_o,
  output logic      [codec_serial_pkg::WORD_BITS-1:0] b_rdata_o
);
  logic [codec_serial_pkg::WORD_BITS-1:0] mem [2*codec_serial_pkg::BUF_WORDS];

  // storage, no reset on the array
  always_ff @(posedge clock_i)
  begin
    if (ce_i && a_wr_i.we)
      mem[a_wr_i.addr] <= a_wr_i.data;
    if (ce_i && b_wr_i.we)
      mem[b_wr_i.addr] <= b_wr_i.data;
  end

  // registered read data
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      a_rdata_o <= '0;
      b_rdata_o <= '0;
    end
    else if (ce_i)
    begin
      a_rdata_o <= mem[a_raddr_i];
      b_rdata_o <= mem[b_raddr_i];
    end
  end
endmodule // buffer_mem

// >>> src/serial_shifter.sv
`timescale 1ns/1ps
// msb-first shift register, loads parallel and shifts in at bit 0
module serial_shifter (
  input  wire logic                                   clock_i,
  input  wire logic                                   rstn_i,
  input  wire logic                                   ce_i,
  input  wire logic                                   clear_i,
  input  wire logic                                   load_i,
  input  wire logic [codec_serial_pkg::WORD_BITS-1:0] load_data_i,
  input  wire logic                                   shift_i,
  input  wire logic                                   sin_i,
  output logic      [codec_serial_pkg::WORD_BITS-1:0] q_o
);
  logic [codec_serial_pkg::WORD_BITS-1:0] q_nxt;

  // next value
  always_comb
  begin
    q_nxt = q_o;
    if (clear_i)
      q_nxt = '0;
    else if (load_i)
      q_nxt = load_data_i;
    else if (shift_i)
      q_nxt = {q_o[codec_serial_pkg::WORD_BITS-2:0], sin_i};
  end

  // register
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      q_o <= '0;
    else if (ce_i)
      q_o <= q_nxt;
  end
endmodule // serial_shifter

// >>> src/converter_serial_unit.sv
`timescale 1ns/1ps
module converter_serial_unit (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        bit_clock_pin_i,
  output logic             bit_clock_pin_o,
  output logic             bit_clock_pin_oe_o,
  input  wire logic        frame_sync_pin_i,
  output logic             frame_sync_pin_o,
  output logic             frame_sync_pin_oe_o,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe_o,
  input  wire logic        serial_in_pin_i
);
  codec_serial_pkg::cfg_type          cfg_r, cfg_nxt;
  codec_serial_pkg::engine_type       eng_r, eng_nxt;
  codec_serial_pkg::engine_state_type state_r, state_nxt;
  codec_serial_pkg::mem_wr_type       mem_a_wr, mem_b_wr;
  logic [15:0] mem_a_rd, mem_b_rd, sh_q, rx_word;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [7:0]  dpa_r, dpa_nxt;
  logic        dp_r, dp_nxt, dpw_r, dpw_nxt, dph_r, dph_nxt;
  logic        hready_r, hready_nxt, hresp_r;
  logic        bclk_s1, bclk_s2, bclk_s3, fs_s1, fs_s2, sdi_s1, sdi_s2;
  logic        bck_tick, bck_rise, bck_fall, framing, slot_on, word_end;
  logic        sh_load, sh_shift;

  // buffer word region decode
  function automatic logic is_buf(input logic [7:0] a);
    return a[7:5] == codec_serial_pkg::OFS_BUF_REGION;
  endfunction

  // word index inside the buffer region, top bit picks tx
  function automatic logic [2:0] buf_index(input logic [7:0] a);
    return {a[4], a[3:2]};
  endfunction

  // ahb-lite slave: one wait state, then registered answer
  always_comb
  begin
    dp_nxt     = dp_r;
    dpw_nxt    = dpw_r;
    dpa_nxt    = dpa_r;
    dph_nxt    = dph_r;
    hready_nxt = hready_r;
    hrdata_nxt = hrdata_r;
    cfg_nxt    = cfg_r;
    mem_a_wr   = '0;
    if (dp_r)
    begin
      dp_nxt     = 1'b0;
      hready_nxt = 1'b1;
      hrdata_nxt = '0;
      if (dpw_r && dph_r)
      begin
        case (dpa_r)
          codec_serial_pkg::OFS_CTRL_ONE:
          begin
            cfg_nxt.enable    = hwdata_i[codec_serial_pkg::EN_POS];
            cfg_nxt.fs_dir    = hwdata_i[codec_serial_pkg::FSD_POS];
            cfg_nxt.idle_mode = hwdata_i[codec_serial_pkg::IDLE_POS];
          end
          codec_serial_pkg::OFS_CTRL_TWO:
          begin
            cfg_nxt.ws      = hwdata_i[codec_serial_pkg::WS_LSB +: 4];
            cfg_nxt.fsg     = hwdata_i[codec_serial_pkg::FSG_LSB +: 4];
            cfg_nxt.bck_dir = hwdata_i[codec_serial_pkg::BCKD_POS];
          end
          codec_serial_pkg::OFS_CTRL_THREE:
            cfg_nxt.bcg = hwdata_i[codec_serial_pkg::BCG_LSB +: 12];
          codec_serial_pkg::OFS_SLOT_MASK:
            cfg_nxt.slot_mask = hwdata_i[15:0];
          default:
            if (is_buf(dpa_r) && dpa_r[4])
              mem_a_wr = '{1'b1, buf_index(dpa_r), hwdata_i[15:0]};
        endcase
      end
      else if (dph_r)
      begin
        case (dpa_r)
          codec_serial_pkg::OFS_CTRL_ONE:
            hrdata_nxt = {29'h0, cfg_r.idle_mode, cfg_r.fs_dir, cfg_r.enable};
          codec_serial_pkg::OFS_CTRL_TWO:
            hrdata_nxt = {23'h0, cfg_r.bck_dir, cfg_r.fsg, cfg_r.ws};
          codec_serial_pkg::OFS_CTRL_THREE:
            hrdata_nxt = {20'h0, cfg_r.bcg};
          codec_serial_pkg::OFS_SLOT_MASK:
            hrdata_nxt = {16'h0, cfg_r.slot_mask};
          codec_serial_pkg::OFS_STATUS:
            hrdata_nxt = {28'h0, state_r == codec_serial_pkg::ENG_RUN, eng_r.in_frame,
                          eng_r.buf_addr};
          default:
            hrdata_nxt = is_buf(dpa_r) ? {16'h0, mem_a_rd} : 32'h0;
        endcase
      end
    end
    else if (hsel_i && htrans_i[1] && hready_i)
    begin
      dp_nxt     = 1'b1;
      dpw_nxt    = hwrite_i;
      dpa_nxt    = haddr_i[7:0];
      dph_nxt    = haddr_i[31:8] == 24'h0;
      hready_nxt = 1'b0;
    end
  end

  // ahb-lite slave registers
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      dp_r     <= 1'b0;
      dpw_r    <= 1'b0;
      dpa_r    <= 8'h00;
      dph_r    <= 1'b0;
      hready_r <= 1'b1;
      hrdata_r <= 32'h0;
      hresp_r  <= 1'b0;
      cfg_r    <= codec_serial_pkg::CFG_RST;
    end
    else if (ce_i)
    begin
      dp_r     <= dp_nxt;
      dpw_r    <= dpw_nxt;
      dpa_r    <= dpa_nxt;
      dph_r    <= dph_nxt;
      hready_r <= hready_nxt;
      hrdata_r <= hrdata_nxt;
      cfg_r    <= cfg_nxt;
    end
  end

  // pin synchronisers; stage one feeds only stage two
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      {bclk_s1, bclk_s2, bclk_s3} <= 3'h0;
      {fs_s1, fs_s2, sdi_s1, sdi_s2} <= 4'h0;
    end
    else if (ce_i)
    begin
      bclk_s1 <= bit_clock_pin_i;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      fs_s1   <= frame_sync_pin_i;
      fs_s2   <= fs_s1;
      sdi_s1  <= serial_in_pin_i;
      sdi_s2  <= sdi_s1;
    end
  end

  // bit clock edges: own divider as master, pin edges as slave
  always_comb
  begin
    bck_tick = cfg_r.enable && !cfg_r.bck_dir && (cfg_r.bcg != 12'h000) &&
               (eng_r.bcg_cnt >= cfg_r.bcg);
    if (cfg_r.bck_dir)
    begin
      bck_rise = cfg_r.enable && bclk_s2 && !bclk_s3;
      bck_fall = cfg_r.enable && !bclk_s2 && bclk_s3;
    end
    else
    begin
      bck_rise = bck_tick && !eng_r.bclk;
      bck_fall = bck_tick && eng_r.bclk;
    end
  end

  // frame and word status
  assign framing  = cfg_r.fs_dir ? (eng_r.in_frame || eng_r.start_pend) : 1'b1;
  assign slot_on  = cfg_r.slot_mask[eng_r.slot_cnt];
  assign word_end = bck_fall && framing && (eng_r.bit_cnt == cfg_r.ws);
  assign rx_word  = {sh_q[14:0], sdi_s2} << (4'hF - cfg_r.ws);

  // serial engine next state
  always_comb
  begin
    eng_nxt   = eng_r;
    state_nxt = state_r;
    sh_load   = 1'b0;
    sh_shift  = 1'b0;
    mem_b_wr  = '0;
    if (!cfg_r.enable)
    begin
      eng_nxt   = codec_serial_pkg::ENG_RST;
      state_nxt = codec_serial_pkg::ENG_IDLE;
    end
    else
    begin
      case (state_r)
        codec_serial_pkg::ENG_IDLE: state_nxt = codec_serial_pkg::ENG_RUN;
        codec_serial_pkg::ENG_RUN:  state_nxt = codec_serial_pkg::ENG_RUN;
        default:                    state_nxt = codec_serial_pkg::ENG_IDLE;
      endcase
      eng_nxt.bck_oe = !cfg_r.bck_dir;
      eng_nxt.fs_oe  = !cfg_r.fs_dir;
      if (bck_tick)
      begin
        eng_nxt.bcg_cnt = 12'h000;
        eng_nxt.bclk    = !eng_r.bclk;
      end
      else if (!cfg_r.bck_dir && cfg_r.bcg != 12'h000)
        eng_nxt.bcg_cnt = eng_r.bcg_cnt + 12'h001;
      else
        eng_nxt.bcg_cnt = 12'h000;
      // rising edge: drive the next bit and the frame sync
      if (bck_rise)
      begin
        if (framing)
        begin
          eng_nxt.in_frame   = cfg_r.fs_dir;
          eng_nxt.start_pend = 1'b0;
          eng_nxt.fs_out     = !cfg_r.fs_dir && eng_r.bit_cnt == 4'h0 &&
                               eng_r.slot_cnt == 4'h0;
          eng_nxt.sdo_oe     = slot_on || cfg_r.idle_mode;
          if (eng_r.bit_cnt == 4'h0)
          begin
            sh_load     = 1'b1;
            eng_nxt.sdo = slot_on && mem_b_rd[15];
          end
          else
            eng_nxt.sdo = slot_on && sh_q[15];
        end
        else
        begin
          eng_nxt.fs_out = 1'b0;
          eng_nxt.sdo    = 1'b0;
          eng_nxt.sdo_oe = cfg_r.idle_mode;
        end
      end
      // falling edge: sample, count bits, slots and buffer words
      if (bck_fall)
      begin
        if (cfg_r.fs_dir && !framing && fs_s2)
          eng_nxt.start_pend = 1'b1;
        if (framing)
        begin
          sh_shift = 1'b1;
          if (word_end)
          begin
            eng_nxt.bit_cnt = 4'h0;
            if (slot_on)
            begin
              mem_b_wr         = '{1'b1, {1'b0, eng_r.buf_addr}, rx_word};
              eng_nxt.buf_addr = eng_r.buf_addr + 2'h1;
            end
            if (eng_r.slot_cnt == cfg_r.fsg)
            begin
              eng_nxt.slot_cnt = 4'h0;
              eng_nxt.in_frame = 1'b0;
            end
            else
              eng_nxt.slot_cnt = eng_r.slot_cnt + 4'h1;
          end
          else
            eng_nxt.bit_cnt = eng_r.bit_cnt + 4'h1;
        end
      end
    end
  end

  // serial engine registers
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      eng_r   <= codec_serial_pkg::ENG_RST;
      state_r <= codec_serial_pkg::ENG_IDLE;
    end
    else if (ce_i)
    begin
      eng_r   <= eng_nxt;
      state_r <= state_nxt;
    end
  end

  // shadow buffer; tx side read at counter with a 1 on top
  buffer_mem u_buf (
    .clock_i   (clock_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .a_wr_i    (mem_a_wr),
    .a_raddr_i (buf_index(haddr_i[7:0])),
    .b_wr_i    (mem_b_wr),
    .b_raddr_i ({1'b1, eng_r.buf_addr}),
    .a_rdata_o (mem_a_rd),
    .b_rdata_o (mem_b_rd)
  );

  // shared shift register for both directions
  serial_shifter u_shift (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .clear_i     (!cfg_r.enable),
    .load_i      (sh_load),
    .load_data_i (mem_b_rd),
    .shift_i     (sh_shift),
    .sin_i       (sdi_s2),
    .q_o         (sh_q)
  );

  // outputs, all from flops
  assign hrdata_o            = hrdata_r;
  assign hreadyout_o         = hready_r;
  assign hresp_o             = hresp_r;
  assign bit_clock_pin_o     = eng_r.bclk;
  assign bit_clock_pin_oe_o  = eng_r.bck_oe;
  assign frame_sync_pin_o    = eng_r.fs_out;
  assign frame_sync_pin_oe_o = eng_r.fs_oe;
  assign serial_out_pin_o    = eng_r.sdo;
  assign serial_out_pin_oe_o = eng_r.sdo_oe;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  pins_released_a: assert property (ce_i && !cfg_r.enable |=>
    !bit_clock_pin_oe_o && !frame_sync_pin_oe_o && !serial_out_pin_oe_o)
    else $error("pins still driven while disabled");
  disable_reset_a: assert property (ce_i && !cfg_r.enable |=>
    eng_r.bit_cnt == 4'h0 && eng_r.slot_cnt == 4'h0 && eng_r.buf_addr == 2'h0 && !eng_r.bclk)
    else $error("counters not cleared by disable");
  clock_dir_a: assert property (ce_i && cfg_r.enable |=>
    bit_clock_pin_oe_o == !$past(cfg_r.bck_dir))
    else $error("bit clock direction wrong");
  sync_dir_a: assert property (ce_i && cfg_r.enable |=>
    frame_sync_pin_oe_o == !$past(cfg_r.fs_dir))
    else $error("frame sync direction wrong");
  idle_low_a: assert property (ce_i && bck_rise && !slot_on && cfg_r.idle_mode |=>
    serial_out_pin_oe_o && !serial_out_pin_o)
    else $error("idle bit not driven low");
  idle_float_a: assert property (ce_i && bck_rise && !slot_on && !cfg_r.idle_mode |=>
    !serial_out_pin_oe_o)
    else $error("idle bit not released");
  msb_first_a: assert property (ce_i && sh_load && slot_on |=>
    serial_out_pin_o == $past(mem_b_rd[15]))
    else $error("first bit is not the msb");
  rx_zero_low_a: assert property (mem_b_wr.we |->
    (mem_b_wr.data & (16'hFFFF >> (5'(cfg_r.ws) + 5'h01))) == 16'h0000)
    else $error("unused receive bits not zero");
  rx_prefix_a: assert property (mem_b_wr.we |->
    mem_b_wr.addr == {1'b0, eng_r.buf_addr})
    else $error("receive address prefix wrong");
  addr_step_a: assert property (ce_i && mem_b_wr.we && cfg_r.enable |=>
    eng_r.buf_addr == $past(eng_r.buf_addr) + 2'h1)
    else $error("buffer counter did not step");

  word_done_c: cover property (mem_b_wr.we);
  addr_wrap_c: cover property (mem_b_wr.we && eng_r.buf_addr == 2'h3);
  slave_start_c: cover property (eng_r.start_pend ##[1:40] eng_r.in_frame);
  bus_write_c: cover property (mem_a_wr.we);
endmodule // converter_serial_unit

// >>> test/codec_model.sv
`timescale 1ns/1ps
// codec on the far side: makes bit clock and frame sync, swaps one word per slot
module codec_model (
  input  wire logic        go_i,
  input  wire logic [3:0]  ws_i,
  input  wire logic [3:0]  fsg_i,
  input  wire logic [63:0] words_i,
  input  wire logic        sdo_i,
  output logic             bclk_o,
  output logic             fs_o,
  output logic             sdi_o,
  output logic             valid_o,
  output logic [15:0]      word_o
);
  logic [15:0] w;
  // idle levels, clock stands still outside frames
  initial
  begin
    bclk_o = 1'b0;
    fs_o = 1'b0;
    sdi_o = 1'b0;
    valid_o = 1'b0;
    word_o = 16'h0000;
  end
  // one frame per go: a sync bit, then fsg+1 words of ws+1 bits, msb first
  always @(posedge go_i)
  begin
    // codec clock is unrelated to the system clock: keep its edges off the clock edge
    #5;
    bclk_o = 1'b1;
    fs_o = 1'b1;
    #80 bclk_o = 1'b0;
    #80 fs_o = 1'b0;
    for (int k = 0; k <= fsg_i; k++)
    begin
      w = words_i[16*(k%4) +: 16];
      word_o = 16'h0000;
      for (int b = 0; b <= ws_i; b++)
      begin
        bclk_o = 1'b1;
        sdi_o = w[15-b];
        #80 bclk_o = 1'b0;
        #70 word_o[15-b] = sdo_i;
        #10;
      end
      valid_o = 1'b1;
      #1 valid_o = 1'b0;
    end
    sdi_o = ~sdi_o; // released line must not show the last bit
  end
endmodule // codec_model

// >>> test/tb.sv
`timescale 1ns/1ps
// self-checking bench: bus master, codec partner, queued expectations
module tb;
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o, rd_ph, p_go;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic        bit_clock_pin_i, bit_clock_pin_o, bit_clock_pin_oe_o;
  logic        frame_sync_pin_i, frame_sync_pin_o, frame_sync_pin_oe_o;
  logic        serial_out_pin_o, serial_out_pin_oe_o, serial_in_pin_i;
  logic        p_bclk, p_fs, p_valid, sdo_w;
  logic [15:0] p_word;
  logic [3:0]  p_ws, p_fsg;
  logic [63:0] p_words;
  logic [15:0] tx [4];
  logic [15:0] rx_exp [4];
  logic [15:0] slot_q [$];
  logic [31:0] rd_q [$];
  logic [8:0]  cases [3] = '{9'h1FF, 9'h174, 9'h005};
  int          n_fail = 0;
  int          num_checks = 0;

  always #10 clock_i = ~clock_i;

  // wire levels from both parties
  assign hready_i = hreadyout_o;
  assign bit_clock_pin_i = bit_clock_pin_oe_o ? bit_clock_pin_o : p_bclk;
  assign frame_sync_pin_i = frame_sync_pin_oe_o ? frame_sync_pin_o : p_fs;
  assign sdo_w = serial_out_pin_oe_o ? serial_out_pin_o : 1'bz;

  converter_serial_unit i_converter_serial_unit (
    .clock_i, .rstn_i, .ce_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .bit_clock_pin_i,
    .bit_clock_pin_o, .bit_clock_pin_oe_o, .frame_sync_pin_i, .frame_sync_pin_o,
    .frame_sync_pin_oe_o, .serial_out_pin_o, .serial_out_pin_oe_o, .serial_in_pin_i
  );

  codec_model i_codec_model (
    .go_i(p_go), .ws_i(p_ws), .fsg_i(p_fsg), .words_i(p_words), .sdo_i(sdo_w),
    .bclk_o(p_bclk), .fs_o(p_fs), .sdi_o(serial_in_pin_i), .valid_o(p_valid),
    .word_o(p_word)
  );

  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one clock of a bounded wait
  task automatic step(inout int n, input int lim);
    @(posedge clock_i);
    n++;
    if (n > lim)
    begin
      n_fail++;
      $display("unexpected at %0t: wait ran out", $time);
      finish_test();
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    step(n, 50);
    while (hready_i !== 1'b1)
      step(n, 50);
  endtask

  // single word transfer; for a read, d is the expected data
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr;
    wait_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rd_ph <= ~wr;
    if (!wr)
      rd_q.push_back(d);
    wait_rdy();
    rd_ph <= 1'b0;
  endtask

  // left-justified word: kind 0 data, 1 floating, 2 driven low
  function automatic logic [15:0] lj(input logic [15:0] w, input logic [3:0] ws, input int kind);
    logic [15:0] e;
    e = 16'h0000;
    for (int b = 0; b <= ws; b++)
      e[15-b] = (kind == 0) ? w[15-b] : ((kind == 1) ? 1'bz : 1'b0);
    return e;
  endfunction

  // result watchers take the oldest note
  always @(posedge clock_i)
    if (rd_ph === 1'b1 && hready_i === 1'b1)
      chk(hrdata_o, rd_q.pop_front(), "read");

  always @(posedge p_valid)
    chk({16'h0000, p_word}, {16'h0000, slot_q.pop_front()}, "slot");

  // main sequence
  initial
  begin
    int cnt;
    int n;
    hsel_i = 1'b0;
    htrans_i = 2'h0;
    haddr_i = 32'h00000000;
    hwrite_i = 1'b0;
    hwdata_i = 32'h00000000;
    rd_ph = 1'b0;
    p_go = 1'b0;
    void'($urandom(89));
    repeat (5) @(posedge clock_i);
    rstn_i <= 1'b1;
    chk({bit_clock_pin_oe_o, frame_sync_pin_oe_o, serial_out_pin_oe_o, hreadyout_o},
        32'h1, "reset");
    bus(1'b1, 32'h4, 32'h000001F7);
    bus(1'b0, 32'h4, 32'h000001F7);
    bus(1'b1, 32'h100, 32'hFFFFFFFF);
    bus(1'b0, 32'h100, 32'h00000000);
    // slave frames: sixteen slots, short words with floating idle, one short slot
    for (int c = 0; c < 3; c++)
    begin
      {p_fsg, p_ws} = cases[c][8:1];
      p_words = {$urandom, $urandom};
      bus(1'b1, 32'h0, 32'h0);
      bus(1'b1, 32'h4, {23'h0, 1'b1, p_fsg, p_ws});
      bus(1'b1, 32'h8, 32'h0);
      bus(1'b1, 32'hC, 32'h0000FFFB);
      for (int i = 0; i < 4; i++)
      begin
        tx[i] = 16'($urandom);
        bus(1'b1, 32'h30 + 32'(4 * i), {16'h0000, tx[i]});
      end
      bus(1'b1, 32'h0, {29'h0, cases[c][0], 2'b11});
      @(posedge clock_i);
      chk({bit_clock_pin_oe_o, frame_sync_pin_oe_o}, 32'h0, "slave pins");
      cnt = 0;
      for (int k = 0; k <= p_fsg; k++)
        if (k != 2)
        begin
          slot_q.push_back(lj(tx[cnt], p_ws, 0));
          rx_exp[cnt] = lj(p_words[16*(k%4) +: 16], p_ws, 0);
          cnt = (cnt + 1) % 4;
        end
        else
          slot_q.push_back(lj(16'h0000, p_ws, cases[c][0] ? 2 : 1));
      p_go = 1'b1;
      n = 0;
      while (slot_q.size() != 0)
        step(n, 5000);
      p_go = 1'b0;
      for (int i = 3; i >= 0; i--)
        bus(1'b0, 32'h20 + 32'(4 * i), {16'h0000, rx_exp[i]});
      bus(1'b1, 32'h0, 32'h0);
      bus(1'b0, 32'h10, 32'h0);
    end
    // master clock and frame sync
    bus(1'b1, 32'h8, 32'h1);
    bus(1'b1, 32'h4, 32'h0000000F);
    bus(1'b1, 32'h0, 32'h1);
    n = 0;
    while (frame_sync_pin_o !== 1'b1)
      step(n, 300);
    chk({bit_clock_pin_oe_o, frame_sync_pin_oe_o, serial_out_pin_oe_o},
        32'h7, "master");
    // clock enable low must hold the bit clock high where it would otherwise fall
    ce_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk({bit_clock_pin_o, frame_sync_pin_o}, 32'h3, "frozen");
    ce_i <= 1'b1;
    bus(1'b1, 32'h0, 32'h0);
    repeat (2) @(posedge clock_i);
    chk({bit_clock_pin_o, bit_clock_pin_oe_o, frame_sync_pin_oe_o}, 32'h0, "off");
    finish_test();
  end
endmodule // tb
